// >>> rtl/synth_ctl_consts.vh
`ifndef SYNTH_CTL_CONSTS_VH
`define SYNTH_CTL_CONSTS_VH
// ----------------------------------------
// Address and byte layout
// ----------------------------------------
`define ADDR_FIXED_HI 5'h18
`define BYTE_SEL_BIT 7
`define RW_WRITE 1'b0
// ----------------------------------------
// Power-on defaults of the four staged bytes
// ----------------------------------------
`define CTL_B_TOP_RESET 4'h1
`define CTL_B_BIT2_RESET 1'b1
`define CTL_A_RESET 8'h80
`define RATIO_HI_RESET 8'h00
`define RATIO_LO_RESET 8'h00
// ----------------------------------------
// Byte sequence positions
// ----------------------------------------
`define SEQ_B2 2'd0
`define SEQ_B3 2'd1
`define SEQ_B4 2'd2
`define SEQ_B5 2'd3
// ----------------------------------------
// Strap decode codes
// ----------------------------------------
`define STRAP_LOW 2'd0
`define STRAP_OPEN 2'd1
`define STRAP_MID 2'd2
`define STRAP_HIGH 2'd3
`endif

// >>> rtl/line_sync.v
`timescale 1ns/1ps
// ----------------------------------------
// Two flop synchroniser per bit
// ----------------------------------------
module line_sync #(
  parameter WIDTH = 2
) (
  input wire core_clk,
  input wire resetn,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage_one; // First stage, read only by second

  // Two flops, idle high for bus lines
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stage_one <= {WIDTH{1'b1}};
      sync_out <= {WIDTH{1'b1}};
    end
    else
    begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end
endmodule

// >>> rtl/ref_ratio_lut.v
`timescale 1ns/1ps
// ----------------------------------------
// Reference divider ratio lookup
// ----------------------------------------
module ref_ratio_lut (
  input wire [3:0] code,
  output reg [8:0] ratio
);
  // Code to divide ratio
  always @*
  begin
    case (code)
      4'h0: ratio = 9'd2;
      4'h1: ratio = 9'd4;
      4'h2: ratio = 9'd8;
      4'h3: ratio = 9'd16;
      4'h4: ratio = 9'd32;
      4'h5: ratio = 9'd64;
      4'h6: ratio = 9'd128;
      4'h7: ratio = 9'd256;
      4'h8: ratio = 9'd24;
      4'h9: ratio = 9'd5;
      4'hA: ratio = 9'd10;
      4'hB: ratio = 9'd20;
      4'hC: ratio = 9'd40;
      4'hD: ratio = 9'd80;
      4'hE: ratio = 9'd160;
      default: ratio = 9'd320;
    endcase
  end
endmodule

// >>> rtl/synth_i2c_write_control.v
`timescale 1ns/1ps
`include "synth_ctl_consts.vh"
module synth_i2c_write_control (
  input wire core_clk,
  input wire resetn,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  input wire [1:0] addr_strap_pin,
  output reg [16:0] main_ratio_bits,
  output reg halve_prescale_en,
  output reg [3:0] ref_ratio_sel,
  output reg [8:0] ref_ratio,
  output reg pump_current_sel_hi,
  output reg pump_current_sel_lo,
  output reg refout_en,
  output reg refout_sel,
  output reg ref_out_oe,
  output reg ref_out_is_comp,
  output reg test_mode,
  output reg [2:0] test_sel,
  output reg port3_out,
  output reg port2_or_test2,
  output reg port1_or_test1,
  output reg port0_or_test0,
  output reg [3:0] port_oe
);
  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  wire [1:0] bus_sync; // Synced scl, sda
  wire [1:0] strap_sync; // Synced strap code
  reg scl_d; // Previous scl
  reg sda_d; // Previous sda
  line_sync #(.WIDTH(2)) u_bus_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .async_in({scl_in, sda_in}),
    .sync_out(bus_sync)
  );
  line_sync #(.WIDTH(2)) u_strap_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .async_in(addr_strap_pin),
    .sync_out(strap_sync)
  );
  wire scl_s = bus_sync[1]; // Synced bus clock
  wire sda_s = bus_sync[0]; // Synced bus data
  // ----------------------------------------
  // Bus edge and condition detect
  // ----------------------------------------
  // Sync lag is a few core cycles, far inside any
  // fast mode clock phase, so bits are taken safely
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  // Data moving while clock high marks START or STOP
  wire start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det = scl_s & scl_d & ~sda_d & sda_s;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Strap code to address bits
  function [1:0] strap_decode;
    input [1:0] code;
    begin
      case (code)
        `STRAP_LOW: strap_decode = 2'b00;
        `STRAP_OPEN: strap_decode = 2'b01;
        `STRAP_MID: strap_decode = 2'b10;
        default: strap_decode = 2'b11;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Bus state machine
  // ----------------------------------------
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_ACK = 3'd2;
  localparam ST_DATA = 3'd3;
  localparam ST_IGNORE = 3'd4;
  reg [2:0] state; // Bus state
  reg [3:0] bit_cnt; // Bits shifted this byte
  reg [7:0] shift; // Incoming byte
  reg is_addr; // Ack belongs to address byte
  reg first_data; // Next data byte is first
  reg [1:0] seq; // Expected byte position
  reg ack_hold; // Ack clock high phase seen
  // ----------------------------------------
  // Byte staging
  // ----------------------------------------
  // Staged bytes, held apart from the active set
  // so a sweep of bytes 2 and 3 moves the ratio only at STOP
  reg [7:0] main_ratio_high; // Byte 2 stage
  reg [7:0] main_ratio_low; // Byte 3 stage
  reg [7:0] loop_control_a; // Byte 4 stage
  reg [7:0] loop_control_b; // Byte 5 stage
  reg [3:0] got; // Bytes seen this transfer
  reg apply; // Pulse to load active set
  reg [1:0] my_addr; // Decoded strap bits
  // Shift register input, MSB first
  wire [7:0] rx_byte = {shift[6:0], sda_s};
  // Byte is complete in shift at the clock fall after bit 8,
  // so its first bit is read from shift, not rx_byte
  wire [1:0] pos = first_data ? (shift[`BYTE_SEL_BIT] ? `SEQ_B4 : `SEQ_B2) : seq;

  // ----------------------------------------
  // Strap capture
  // ----------------------------------------
  // Strap latched every clock after reset release
  // Strap is static, so resampling costs nothing
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      my_addr <= 2'b00;
    else
      my_addr <= strap_decode(strap_sync);
  end

  // Edges of the bus lines
  // Previous levels reset to the idle high of the pins
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Receive, acknowledge and stage bytes
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      // Idle bus, nothing driven
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      is_addr <= 1'b0;
      first_data <= 1'b0;
      seq <= `SEQ_B2;
      ack_hold <= 1'b0;
      // Staged bytes take power-on values
      main_ratio_high <= `RATIO_HI_RESET;
      main_ratio_low <= `RATIO_LO_RESET;
      loop_control_a <= `CTL_A_RESET;
      loop_control_b <= {`CTL_B_TOP_RESET, 1'b0, `CTL_B_BIT2_RESET, 2'b00};
      got <= 4'h0;
      apply <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end
    else
    begin
      apply <= 1'b0;
      sda_out <= 1'b0;
      if (stop_det)
      begin
        // STOP ends transfer; partial set applied
        state <= ST_IDLE;
        sda_oe <= 1'b0;
        if (got != 4'h0)
          apply <= 1'b1;
        got <= 4'h0;
      end
      else if (start_det)
      begin
        // START or repeated START
        state <= ST_ADDR;
        bit_cnt <= 4'h0;
        sda_oe <= 1'b0;
        got <= 4'h0;
      end
      else
      begin
        case (state)
          ST_ADDR, ST_DATA:
          begin
            // Shift on clock rise, act on the fall after bit 8
            if (scl_rise)
            begin
              shift <= rx_byte;
              bit_cnt <= bit_cnt + 4'h1;
            end
            if (scl_fall && bit_cnt == 4'd8)
            begin
              bit_cnt <= 4'h0;
              if (state == ST_ADDR)
              begin
                // Address check, write only
                if (shift[7:3] == `ADDR_FIXED_HI && shift[2:1] == my_addr &&
                    shift[0] == `RW_WRITE)
                begin
                  state <= ST_ACK;
                  is_addr <= 1'b1;
                  first_data <= 1'b1;
                  sda_oe <= 1'b1;
                end
                else
                  state <= ST_IGNORE;
              end
              else
              begin
                // Stage byte at its position
                case (pos)
                  `SEQ_B2: main_ratio_high <= shift;
                  `SEQ_B3: main_ratio_low <= shift;
                  `SEQ_B4: loop_control_a <= shift;
                  default: loop_control_b <= shift;
                endcase
                // Next position wraps after byte 5
                seq <= pos + 2'd1;
                first_data <= 1'b0;
                // Full set: every position seen, close the group
                if ((got | (4'h1 << pos)) == 4'hF)
                begin
                  apply <= 1'b1;
                  got <= 4'h0;
                end
                else
                  got <= got | (4'h1 << pos);
                state <= ST_ACK;
                is_addr <= 1'b0;
                sda_oe <= 1'b1;
              end
            end
          end
          ST_ACK:
          begin
            // Ack stands through the whole clock high phase
            // Release after the ack clock pulse
            if (scl_rise)
              ack_hold <= 1'b1;
            if (scl_fall && ack_hold)
            begin
              ack_hold <= 1'b0;
              sda_oe <= 1'b0;
              state <= ST_DATA;
            end
          end
          // Foreign address or read: stay quiet until START
          ST_IGNORE:
            sda_oe <= 1'b0;
          // Idle: wait for START
          default:
            sda_oe <= 1'b0;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Active register set
  // ----------------------------------------
  wire [8:0] lut_ratio; // Decoded reference ratio
  ref_ratio_lut u_lut (
    .code(loop_control_a[3:0]),
    .ratio(lut_ratio)
  );
  // Test mode: reference output off, select set
  wire tmode = ~loop_control_b[5] & loop_control_b[4];

  // Load active outputs on apply
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      // Bits left open at power-on come up as zero
      main_ratio_bits <= 17'h0_0000;
      halve_prescale_en <= 1'b0;
      ref_ratio_sel <= 4'h0;
      ref_ratio <= 9'd2;
      pump_current_sel_hi <= 1'b0;
      pump_current_sel_lo <= 1'b0;
      refout_en <= 1'b0;
      refout_sel <= 1'b1;
      ref_out_oe <= 1'b0;
      ref_out_is_comp <= 1'b0;
      test_mode <= 1'b1;
      // Test select follows the power-on low bits of byte 5
      test_sel <= {`CTL_B_BIT2_RESET, 2'b00};
      port3_out <= 1'b0;
      port2_or_test2 <= `CTL_B_BIT2_RESET;
      port1_or_test1 <= 1'b0;
      port0_or_test0 <= 1'b0;
      port_oe <= 4'h0;
    end
    else if (apply)
    begin
      // Whole set moves together on one apply
      main_ratio_bits <= {loop_control_a[6:5], main_ratio_high[6:0],
                          main_ratio_low};
      halve_prescale_en <= loop_control_a[4];
      ref_ratio_sel <= loop_control_a[3:0];
      ref_ratio <= lut_ratio;
      pump_current_sel_hi <= loop_control_b[7];
      pump_current_sel_lo <= loop_control_b[6];
      refout_en <= loop_control_b[5];
      refout_sel <= loop_control_b[4];
      ref_out_oe <= loop_control_b[5];
      ref_out_is_comp <= loop_control_b[5] & loop_control_b[4];
      test_mode <= tmode;
      test_sel <= tmode ? loop_control_b[2:0] : 3'b000;
      port3_out <= loop_control_b[3];
      port2_or_test2 <= loop_control_b[2];
      port1_or_test1 <= loop_control_b[1];
      port0_or_test0 <= loop_control_b[0];
      // Open collector: enable pulls low when bit is 1, except port 0 in test mode
      port_oe <= {loop_control_b[3:1], loop_control_b[0] & ~tmode};
    end
  end
endmodule

// >>> tb/synth_chk_sva.sv
`timescale 1ns/1ps
module synth_chk_sva (
  input wire core_clk,
  input wire resetn,
  input wire scl_in,
  input wire sda_out,
  input wire sda_oe,
  input wire refout_en,
  input wire refout_sel,
  input wire ref_out_oe,
  input wire ref_out_is_comp,
  input wire test_mode,
  input wire [2:0] test_sel,
  input wire port2_or_test2,
  input wire port1_or_test1,
  input wire port0_or_test0,
  input wire [3:0] port_oe,
  input wire [3:0] ref_ratio_sel,
  input wire [8:0] ref_ratio
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Expected reference ratio per code
  function automatic [8:0] lut(input [3:0] c);
    if (c == 4'h8)
      lut = 9'h018;
    else
      lut = c[3] ? (9'h005 << (c[2:0] - 3'h1)) : (9'h002 << c[2:0]);
  endfunction
  // ----------------------------------------
  // Assertions and covers
  // ----------------------------------------
  a_ratio_map: assert property (
    $stable(ref_ratio_sel) |-> ref_ratio == lut(ref_ratio_sel))
    else $error("reference ratio off table");
  a_refout_drive: assert property (
    $stable(refout_en) |-> ref_out_oe == refout_en)
    else $error("reference pin drive wrong");
  a_comp_pick: assert property (
    $stable({refout_en, refout_sel}) |-> ref_out_is_comp == (refout_en & refout_sel))
    else $error("reference source wrong");
  a_test_enter: assert property (
    $stable({refout_en, refout_sel}) |-> test_mode == (!refout_en & refout_sel))
    else $error("test mode entry wrong");
  a_test_field: assert property (
    $stable({test_mode, port2_or_test2, port1_or_test1, port0_or_test0}) |->
    test_sel == (test_mode ? {port2_or_test2, port1_or_test1, port0_or_test0} : 3'h0))
    else $error("test select wrong");
  a_port0_free: assert property (
    test_mode && $stable(test_mode) |-> !port_oe[0])
    else $error("port0 driven in test mode");
  a_ports_float: assert property ($rose(resetn) |-> port_oe == 4'h0)
    else $error("ports driven after reset");
  a_ack_low: assert property ($rose(sda_oe) |-> !scl_in && !sda_out)
    else $error("ack not in clock low");
  a_ack_hold: assert property ($rose(sda_oe) |-> sda_oe [*6])
    else $error("ack released early");
  c_ack: cover property ($rose(sda_oe));
  c_test: cover property ($fell(test_mode));
  c_comp: cover property ($rose(ref_out_is_comp));
endmodule
bind synth_i2c_write_control synth_chk_sva chk (.core_clk(core_clk), .resetn(resetn),
  .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .refout_en(refout_en),
  .refout_sel(refout_sel), .ref_out_oe(ref_out_oe), .ref_out_is_comp(ref_out_is_comp),
  .test_mode(test_mode), .test_sel(test_sel), .port2_or_test2(port2_or_test2),
  .port1_or_test1(port1_or_test1), .port0_or_test0(port0_or_test0), .port_oe(port_oe),
  .ref_ratio_sel(ref_ratio_sel), .ref_ratio(ref_ratio));

// >>> tb/i2c_ctrl_model.sv
`timescale 1ns/1ps
module i2c_ctrl_model (
  output logic scl,
  output logic sda_drv,
  input wire sda_bus
);
  // Bus idles released, clock still
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // One 64 ns bit cell, data set mid low
  task automatic bit_cell(input logic b, output logic seen);
    #16 sda_drv = b;
    #16 scl = 1'b1;
    #16 seen = sda_bus;
    #16 scl = 1'b0;
  endtask
  // Data falls while clock high
  task automatic start();
    sda_drv = 1'b1;
    #16 scl = 1'b1;
    #16 sda_drv = 1'b0;
    #16 scl = 1'b0;
  endtask
  // Byte MSB first, then release for ack
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_cell(b[i], s);
    bit_cell(1'b1, s);
    ack = !s;
  endtask
  // Data rises while clock high
  task automatic stop();
    #16 sda_drv = 1'b0;
    #16 scl = 1'b1;
    #16 sda_drv = 1'b1;
    #16;
  endtask
endmodule

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] addr_strap_pin = 2'h0;
  logic ack;
  int mismatches = 0;
  int samples_checked = 0;
  wire scl, sda_drv, sda_oe, sda_out;
  // Open-drain data wire
  wire sda_bus = sda_drv & ~(sda_oe & ~sda_out);
  wire [16:0] main_ratio_bits;
  wire [8:0] ref_ratio;
  wire [3:0] ref_ratio_sel, port_oe;
  wire [2:0] test_sel;
  wire halve_prescale_en, pump_current_sel_hi, pump_current_sel_lo, refout_en, refout_sel;
  wire ref_out_oe, ref_out_is_comp, test_mode, port3_out;
  wire port2_or_test2, port1_or_test1, port0_or_test0;
  // Control fields in write-byte order
  wire [14:0] ctl_view = {main_ratio_bits[16:15], halve_prescale_en, ref_ratio_sel,
    pump_current_sel_hi, pump_current_sel_lo, refout_en, refout_sel, port3_out,
    port2_or_test2, port1_or_test1, port0_or_test0};
  // Pin drive and test fields
  wire [9:0] misc_view = {ref_out_oe, ref_out_is_comp, test_mode, test_sel, port_oe};
  logic [31:0] row_data [0:4] = '{32'h1234_E54A, 32'h9BB4_7FFF, 32'h0100_0000,
    32'hF000_0000, 32'h8C17_0000};
  int row_n [0:4] = '{4, 4, 1, 1, 2};
  logic [16:0] row_ratio [0:4] = '{17'h1_9234, 17'h0_7FFF, 17'h0_01FF, 17'h1_81FF,
    17'h0_01FF};
  logic [14:0] row_ctl [0:4] = '{15'h654A, 15'h1BB4, 15'h1BB4, 15'h70B4, 15'h0C17};
  logic [9:0] row_misc [0:4] = '{10'h00A, 10'h304, 10'h304, 10'h304, 10'h0F6};
  logic [8:0] ref_tbl [0:15] = '{9'h002, 9'h004, 9'h008, 9'h010, 9'h020, 9'h040,
    9'h080, 9'h100, 9'h018, 9'h005, 9'h00A, 9'h014, 9'h028, 9'h050, 9'h0A0, 9'h140};
  always #2.5 core_clk = ~core_clk;
  i2c_ctrl_model ctl (.scl(scl), .sda_drv(sda_drv), .sda_bus(sda_bus));
  synth_i2c_write_control DUT (.core_clk(core_clk), .resetn(resetn), .scl_in(scl),
    .sda_in(sda_bus), .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_pin(addr_strap_pin),
    .main_ratio_bits(main_ratio_bits), .halve_prescale_en(halve_prescale_en),
    .ref_ratio_sel(ref_ratio_sel), .ref_ratio(ref_ratio),
    .pump_current_sel_hi(pump_current_sel_hi), .pump_current_sel_lo(pump_current_sel_lo),
    .refout_en(refout_en), .refout_sel(refout_sel), .ref_out_oe(ref_out_oe),
    .ref_out_is_comp(ref_out_is_comp), .test_mode(test_mode), .test_sel(test_sel),
    .port3_out(port3_out), .port2_or_test2(port2_or_test2),
    .port1_or_test1(port1_or_test1), .port0_or_test0(port0_or_test0), .port_oe(port_oe));
  // Compare and count
  task automatic chk(input string n, input logic [16:0] e, input logic [16:0] g);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // Verdict and end of run
  task automatic results();
    if (mismatches == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Address byte, n data bytes, optional STOP
  task automatic xfer(input logic [7:0] a, input logic [31:0] d, input int n,
    input logic e, input logic stp);
    ctl.start();
    ctl.send(a, ack);
    chk("addr_ack", e, ack);
    for (int i = 0; i < n; i++)
    begin
      ctl.send(d[31 - 8 * i -: 8], ack);
      chk("data_ack", 1'b1, ack);
    end
    if (stp)
      ctl.stop();
    #40;
  endtask
  // Hang guard
  initial
  begin
    #300000;
    mismatches++;
    results();
  end
  initial
  begin
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (12) @(posedge core_clk);
    chk("por", 5'h03, {pump_current_sel_hi, pump_current_sel_lo, refout_en, refout_sel,
      port2_or_test2});
    chk("por_ports", 4'h0, port_oe);
    chk("por_test", 4'hC, {test_mode, test_sel});
    // Ordinary transfers
    for (int r = 0; r < 5; r++)
    begin
      xfer(8'hC0, row_data[r], row_n[r], 1'b1, 1'b1);
      chk("ratio", row_ratio[r], main_ratio_bits);
      chk("ctl", row_ctl[r], ctl_view);
      chk("misc", row_misc[r], misc_view);
    end
    xfer(8'hC0, 32'h0A55_0000, 2, 1'b1, 1'b0);
    chk("hold", 17'h0_01FF, main_ratio_bits);
    ctl.stop();
    #40;
    chk("stop_apply", 17'h0_0A55, main_ratio_bits);
    xfer(8'hC0, 32'h0102_F017, 4, 1'b1, 1'b0);
    chk("full_apply", 17'h1_8102, main_ratio_bits);
    ctl.send(8'h03, ack);
    chk("more_ack", 1'b1, ack);
    ctl.stop();
    #40;
    chk("wrap", 17'h1_8302, main_ratio_bits);
    // Reset in mid-run with the bus idle
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("rst_ports", 4'h0, port_oe);
    resetn <= 1'b1;
    repeat (12) @(posedge core_clk);
    chk("rst_ctl", 5'h03, {pump_current_sel_hi, pump_current_sel_lo, refout_en, refout_sel,
      port2_or_test2});
    chk("rst_test", 4'hC, {test_mode, test_sel});
    for (int c = 0; c < 16; c++)
    begin
      xfer(8'hC0, {4'h8, c[3:0], 24'h0}, 1, 1'b1, 1'b1);
      chk("ref", ref_tbl[c], ref_ratio);
    end
    xfer(8'hC2, 32'h0, 0, 1'b0, 1'b1);
    xfer(8'hC1, 32'h0, 0, 1'b0, 1'b1);
    for (int s = 0; s < 4; s++)
    begin
      @(posedge core_clk);
      addr_strap_pin <= s[1:0];
      repeat (12) @(posedge core_clk);
      xfer({5'h18, s[1:0], 1'b0}, 32'h0, 0, 1'b1, 1'b1);
    end
    results();
  end
endmodule
